// ===== adc_seq_pkg.sv
package adc_seq_pkg;
    // ****************************************
    // register map, 32-bit APB words, data in the low byte
    // ****************************************
    localparam logic [7:0] OFF_CSR = 8'h00;
    localparam logic [7:0] OFF_CR = 8'h04;
    localparam logic [7:0] OFF_TRG = 8'h08;
    localparam logic [7:0] OFF_RES_BASE = 8'h40;
    localparam logic [7:0] OFF_RES_LAST = 8'hBC;
    localparam int NUM_CH = 16;
    localparam int RES_BITS = 10;
    localparam int CSR_FLAG = 7;
    localparam int CSR_IE = 6;
    localparam int CR_HWTRG = 7;
    localparam int CR_CKS = 6;
    localparam int CR_GO = 5;
    localparam int CR_CONT = 4;
    localparam int TRG_PIN = 7;
    localparam logic [6:0] TRG_RSVD = 7'h7F;
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_SCAN4 = 2'h1;
    localparam logic [1:0] MODE_SCAN12 = 2'h3;
    localparam logic [1:0] GRP_LAST12 = 2'h2;
    localparam logic [9:0] SAR_MSB = 10'h200;

    // ****************************************
    // timing in converter states, converted to clock cycles
    // ****************************************
    localparam int CLK_NS = 40;
    localparam int STATE_NS = 40;
    localparam int SPS = STATE_NS / CLK_NS;
    localparam int TD_SLOW_ST = 20;
    localparam int TD_FAST_ST = 12;
    localparam int SPL_SLOW_ST = 128;
    localparam int SPL_FAST_ST = 64;
    localparam int CONV_SLOW_ST = 518;
    localparam int CONV_FAST_ST = 262;
    localparam int SCAN_SLOW_ST = 512;
    localparam int SCAN_FAST_ST = 256;
    localparam int BIT_SLOW_ST = 37;
    localparam int BIT_FAST_ST = 18;
    // the first delay gives one cycle to the idle hand-off
    localparam logic [8:0] DLY1_SLOW = 9'((TD_SLOW_ST - 1) * SPS);
    localparam logic [8:0] DLY1_FAST = 9'((TD_FAST_ST - 1) * SPS);
    localparam logic [8:0] SPL_SLOW = 9'(SPL_SLOW_ST * SPS);
    localparam logic [8:0] SPL_FAST = 9'(SPL_FAST_ST * SPS);
    localparam logic [8:0] CVT_SLOW = 9'((CONV_SLOW_ST - TD_SLOW_ST - SPL_SLOW_ST) * SPS);
    localparam logic [8:0] CVT_FAST = 9'((CONV_FAST_ST - TD_FAST_ST - SPL_FAST_ST) * SPS);
    localparam logic [8:0] DLYN_SLOW = 9'((SCAN_SLOW_ST - CONV_SLOW_ST + TD_SLOW_ST) * SPS);
    localparam logic [8:0] DLYN_FAST = 9'((SCAN_FAST_ST - CONV_FAST_ST + TD_FAST_ST) * SPS);
    localparam logic [5:0] BIT_SLOW = 6'(BIT_SLOW_ST * SPS);
    localparam logic [5:0] BIT_FAST = 6'(BIT_FAST_ST * SPS);

    typedef struct packed {
        logic hwTriggerEnable;
        logic clockRateSelect;
        logic continuousScanSelect;
        logic pinTriggerSelect;
        logic doneIrqEnable;
        logic [1:0] mode;
        logic [3:0] channelSelect;
    } ctrl_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_DELAY = 2'b01,
        PH_SAMPLE = 2'b10,
        PH_CONVERT = 2'b11
    } phase_t;
endpackage

// ===== adc_sequencer_control.sv
`timescale 1ns/1ps
module adc_sequencer_control
    import adc_seq_pkg::*;
#(
    parameter bit FIRST_UNIT = 1'b1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigger_pin_n,
    input wire logic timerReq,
    input wire logic dmaAck,
    input wire logic cmpIn,
    output logic [3:0] analogChan,
    output logic sampleHold,
    output logic [9:0] dacCode,
    output logic conversionDoneIrq
);
    // ****************************************
    // state
    // ****************************************
    ctrl_t ctrl_q;
    phase_t phase_q;
    logic conversionGo_q;
    logic conversionDoneFlag_q;
    logic flagArmed_q;
    logic [8:0] cnt_q;
    logic [5:0] stepCnt_q;
    logic [9:0] sar_q;
    logic [9:0] mask_q;
    logic [3:0] chan_q;
    logic firstConv_q;
    logic sampleHold_q;
    logic [1:0] trigShift_q;
    logic [RES_BITS-1:0] result_q [NUM_CH];
    logic [7:0] temp_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic isScan(input logic [1:0] m);
        return (m == MODE_SCAN4) || (FIRST_UNIT && m == MODE_SCAN12);
    endfunction

    function automatic logic [3:0] firstChan(input logic [1:0] m, input logic [3:0] sel);
        if (!isScan(m)) begin
            return sel;
        end
        return (m == MODE_SCAN4) ? {sel[3:2], 2'h0} : 4'h0;
    endfunction

    function automatic logic lastInPass(input logic [1:0] m, input logic [3:0] ch, input logic [3:0] sel);
        if (!isScan(m)) begin
            return 1'b1;
        end
        return (ch[1:0] == sel[1:0]) && (m == MODE_SCAN4 || ch[3:2] == GRP_LAST12);
    endfunction

    function automatic logic [3:0] nextChan(input logic [3:0] ch, input logic [3:0] sel);
        if (ch[1:0] != sel[1:0]) begin
            return ch + 4'h1;
        end
        return {ch[3:2] + 2'h1, 2'h0};
    endfunction

    function automatic logic [9:0] sarDecide(input logic [9:0] s, input logic [9:0] m, input logic keep,
                                             input logic tick);
        return (tick && !keep) ? (s & ~m) : s;
    endfunction

    logic setupPh;
    logic wrHit;
    logic [7:0] wb;
    logic [7:0] resOff;
    logic resHit;
    logic mapped;
    logic tick;
    logic storeEv;
    logic passEnd;
    logic stopConv;
    logic swGoWr;
    logic swFlagClr;
    logic pinArmed;
    logic pinFire;
    logic timerFire;
    logic [9:0] finalVal;
    logic fast;

    assign setupPh = psel && !penable;
    assign wrHit = psel && penable && pready_q && pwrite;
    assign wb = pwdata[7:0];
    assign resOff = paddr - OFF_RES_BASE;
    assign resHit = (paddr >= OFF_RES_BASE) && (paddr <= OFF_RES_LAST) && (paddr[1:0] == 2'h0);
    assign mapped = resHit || paddr == OFF_CSR || paddr == OFF_CR || paddr == OFF_TRG;
    assign fast = ctrl_q.clockRateSelect;
    assign tick = (phase_q == PH_CONVERT) && (stepCnt_q == 6'h00) && (mask_q != 10'h000);
    assign finalVal = sarDecide(sar_q, mask_q, cmpIn, tick);
    assign storeEv = (phase_q == PH_CONVERT) && (cnt_q == 9'h000) && conversionGo_q;
    assign passEnd = storeEv && lastInPass(ctrl_q.mode, chan_q, ctrl_q.channelSelect);
    assign stopConv = passEnd && (!isScan(ctrl_q.mode) || !ctrl_q.continuousScanSelect);
    assign swGoWr = wrHit && paddr == OFF_CR;
    assign swFlagClr = wrHit && paddr == OFF_CSR && !wb[CSR_FLAG] && flagArmed_q;
    assign pinArmed = ctrl_q.hwTriggerEnable && ctrl_q.pinTriggerSelect && !conversionGo_q;
    assign pinFire = trigShift_q[1] && pinArmed;
    assign timerFire = ctrl_q.hwTriggerEnable && !ctrl_q.pinTriggerSelect && timerReq;

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= '0;
            ctrl_q.pinTriggerSelect <= 1'b1;
        end else if (wrHit && paddr == OFF_CSR) begin
            ctrl_q.doneIrqEnable <= wb[CSR_IE];
            ctrl_q.mode <= wb[5:4];
            ctrl_q.channelSelect <= wb[3:0];
        end else if (swGoWr) begin
            ctrl_q.hwTriggerEnable <= wb[CR_HWTRG];
            ctrl_q.clockRateSelect <= wb[CR_CKS];
            ctrl_q.continuousScanSelect <= wb[CR_CONT];
        end else if (wrHit && paddr == OFF_TRG) begin
            ctrl_q.pinTriggerSelect <= wb[TRG_PIN];
        end
    end

    // ****************************************
    // start control
    // ****************************************
    // pin is only looked at while go is low, so a restart after the end also waits two states
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            trigShift_q <= 2'h0;
        end else begin
            trigShift_q <= {trigShift_q[0] && pinArmed, pinArmed && !trigger_pin_n};
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            conversionGo_q <= 1'b0;
        end else if (stopConv) begin
            conversionGo_q <= 1'b0;
        end else if (swGoWr) begin
            conversionGo_q <= wb[CR_GO] || conversionGo_q && wb[CR_GO];
        end else if (pinFire || timerFire) begin
            conversionGo_q <= 1'b1;
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= PH_IDLE;
            cnt_q <= '0;
            stepCnt_q <= '0;
            sar_q <= '0;
            mask_q <= '0;
            chan_q <= '0;
            firstConv_q <= 1'b0;
            sampleHold_q <= 1'b0;
        end else if (phase_q != PH_IDLE && !conversionGo_q) begin
            phase_q <= PH_IDLE;
            sampleHold_q <= 1'b0;
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    if (conversionGo_q) begin
                        phase_q <= PH_DELAY;
                        cnt_q <= (fast ? DLY1_FAST : DLY1_SLOW) - 9'h001;
                        chan_q <= firstChan(ctrl_q.mode, ctrl_q.channelSelect);
                        firstConv_q <= 1'b1;
                    end
                end
                PH_DELAY: begin
                    if (cnt_q == 9'h000) begin
                        phase_q <= PH_SAMPLE;
                        cnt_q <= (fast ? SPL_FAST : SPL_SLOW) - 9'h001;
                        sampleHold_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 9'h001;
                    end
                end
                PH_SAMPLE: begin
                    if (cnt_q == 9'h000) begin
                        phase_q <= PH_CONVERT;
                        cnt_q <= (fast ? CVT_FAST : CVT_SLOW) - 9'h001;
                        stepCnt_q <= (fast ? BIT_FAST : BIT_SLOW) - 6'h01;
                        sar_q <= SAR_MSB;
                        mask_q <= SAR_MSB;
                        sampleHold_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 9'h001;
                    end
                end
                PH_CONVERT: begin
                    // one trial bit per step, msb first
                    if (tick) begin
                        sar_q <= finalVal | (mask_q >> 1);
                        mask_q <= mask_q >> 1;
                        stepCnt_q <= (fast ? BIT_FAST : BIT_SLOW) - 6'h01;
                    end else if (mask_q != 10'h000) begin
                        stepCnt_q <= stepCnt_q - 6'h01;
                    end
                    if (cnt_q != 9'h000) begin
                        cnt_q <= cnt_q - 9'h001;
                    end else if (stopConv) begin
                        phase_q <= PH_IDLE;
                    end else begin
                        phase_q <= PH_DELAY;
                        cnt_q <= (fast ? DLYN_FAST : DLYN_SLOW) - 9'h001;
                        firstConv_q <= 1'b0;
                        chan_q <= passEnd ? firstChan(ctrl_q.mode, ctrl_q.channelSelect) :
                            nextChan(chan_q, ctrl_q.channelSelect);
                    end
                end
                default: begin
                    phase_q <= PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result_q[i] <= '0;
            end
        end else if (storeEv) begin
            result_q[chan_q] <= finalVal;
        end
    end

    // ****************************************
    // done flag and interrupt
    // ****************************************
    // a pass that ends in the clearing cycle keeps the flag set
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            conversionDoneFlag_q <= 1'b0;
        end else if (passEnd) begin
            conversionDoneFlag_q <= 1'b1;
        end else if (swFlagClr || dmaAck) begin
            conversionDoneFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flagArmed_q <= 1'b0;
        end else if (setupPh && !pwrite && paddr == OFF_CSR && conversionDoneFlag_q) begin
            flagArmed_q <= 1'b1;
        end else if (!conversionDoneFlag_q) begin
            flagArmed_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= conversionDoneFlag_q && ctrl_q.doneIrqEnable;
        end
    end

    // ****************************************
    // APB slave, no wait states
    // ****************************************
    // read data and the latch are taken in setup so both halves see the same sample
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            temp_q <= '0;
        end else begin
            pready_q <= setupPh;
            pslverr_q <= setupPh && !mapped;
            if (setupPh && !pwrite) begin
                prdata_q <= '0;
                if (paddr == OFF_CSR) begin
                    prdata_q[7:0] <= {conversionDoneFlag_q, ctrl_q.doneIrqEnable, ctrl_q.mode,
                        ctrl_q.channelSelect};
                end else if (paddr == OFF_CR) begin
                    prdata_q[7:0] <= {ctrl_q.hwTriggerEnable, ctrl_q.clockRateSelect, conversionGo_q,
                        ctrl_q.continuousScanSelect, 4'h0};
                end else if (paddr == OFF_TRG) begin
                    prdata_q[7:0] <= {ctrl_q.pinTriggerSelect, TRG_RSVD};
                end else if (resHit && !resOff[2]) begin
                    prdata_q[7:0] <= result_q[resOff[6:3]][9:2];
                    temp_q <= {result_q[resOff[6:3]][1:0], 6'h00};
                end else if (resHit) begin
                    prdata_q[7:0] <= temp_q;
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign analogChan = chan_q;
    assign sampleHold = sampleHold_q;
    assign dacCode = sar_q;
    assign conversionDoneIrq = irq_q;

    // ****************************************
    // checks
    // ****************************************
    logic [9:0] ageCnt_q;
    logic [9:0] segCnt_q;
    logic [3:0] lastCh_q;
    logic [3:0] firstCh_q;

    // first channel as decoded one cycle earlier, so a restart can be compared exactly
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ageCnt_q <= '0;
            segCnt_q <= '0;
            lastCh_q <= '0;
            firstCh_q <= '0;
        end else begin
            firstCh_q <= firstChan(ctrl_q.mode, ctrl_q.channelSelect);
            ageCnt_q <= (phase_q == PH_IDLE) ? 10'h000 : ageCnt_q + 10'h001;
            segCnt_q <= storeEv ? 10'h000 : segCnt_q + 10'h001;
            if (storeEv) begin
                lastCh_q <= chan_q;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_IRQ_RAISE: assert property (conversionDoneFlag_q && ctrl_q.doneIrqEnable |=> conversionDoneIrq)
        else $error("done interrupt not raised");
    AST_IRQ_DROP: assert property ($fell(conversionDoneFlag_q) || $fell(ctrl_q.doneIrqEnable) |=> !conversionDoneIrq)
        else $error("done interrupt not withdrawn");
    // a software abort drops go one cycle before the sequencer reaches idle
    AST_GO_HELD: assert property (phase_q != PH_IDLE && !$past(swGoWr) |-> conversionGo_q)
        else $error("go low while converting");
    AST_GO_END: assert property (stopConv |=> !conversionGo_q && phase_q == PH_IDLE && conversionDoneFlag_q)
        else $error("end of conversion not handled");
    AST_FLAG_FALL: assert property ($fell(conversionDoneFlag_q) |-> $past(swFlagClr || dmaAck))
        else $error("done flag cleared without cause");
    AST_DMA_CLEAR: assert property (dmaAck && !passEnd |=> !conversionDoneFlag_q)
        else $error("dma service left flag set");
    AST_CONT: assert property (passEnd && !stopConv && !swGoWr |=> phase_q == PH_DELAY && conversionGo_q)
        else $error("continuous scan did not continue");
    AST_SINGLE_TIME: assert property (storeEv && firstConv_q |->
        ageCnt_q == (fast ? 10'(CONV_FAST_ST * SPS - 2) : 10'(CONV_SLOW_ST * SPS - 2)))
        else $error("first conversion time wrong");
    AST_SCAN_TIME: assert property (storeEv && !firstConv_q |->
        segCnt_q == (fast ? 10'(SCAN_FAST_ST * SPS - 1) : 10'(SCAN_SLOW_ST * SPS - 1)))
        else $error("scan conversion time wrong");
    AST_PIN: assert property (pinArmed && !trigger_pin_n ##1 pinArmed |-> ##2 conversionGo_q)
        else $error("pin trigger did not set go");
    AST_TIMER: assert property (timerFire && !stopConv && !swGoWr |=> conversionGo_q)
        else $error("timer request did not set go");
    AST_ORDER: assert property (storeEv && !firstConv_q && $past(chan_q) != firstChan(ctrl_q.mode,
        ctrl_q.channelSelect) |-> chan_q > lastCh_q || chan_q == firstChan(ctrl_q.mode, ctrl_q.channelSelect))
        else $error("scan order not ascending");
    AST_RESTART: assert property (phase_q == PH_IDLE && conversionGo_q |=>
        chan_q == firstCh_q)
        else $error("scan did not restart at first channel");

    COV_SINGLE: cover property (stopConv && !isScan(ctrl_q.mode));
    COV_CONT_PASS: cover property (passEnd && !stopConv);
    COV_PIN_START: cover property (pinFire);
    COV_DMA_CLEAR: cover property (dmaAck && conversionDoneFlag_q);
endmodule

// ===== adc_analog_model.sv
`timescale 1ns/1ps
// ****************************************
// analog front end: sample-and-hold plus comparator
// ****************************************
module adc_analog_model
    import adc_seq_pkg::*;
(
    input wire logic clock,
    input wire logic [3:0] analogChan,
    input wire logic sampleHold,
    input wire logic [9:0] dacCode,
    input wire logic [9:0] seed,
    output logic cmpIn
);
    logic [9:0] held;
    // the held level stays put once sampling ends, as a real hold capacitor would
    always_ff @(posedge clock) begin
        if (sampleHold) begin
            held <= seed ^ {analogChan, 6'h15};
        end
    end
    assign cmpIn = (held >= dacCode);
endmodule

// ===== test_adc_sequencer_control.sv
`timescale 1ns/1ps
module test_adc_sequencer_control;
    import adc_seq_pkg::*;
    logic clock, sys_rst, psel, penable, pwrite, trigger_pin_n, timerReq, dmaAck, cmpIn, pready, pslverr, e;
    logic sampleHold, conversionDoneIrq, shPrev;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] analogChan, c;
    logic [1:0] g, k;
    logic [9:0] dacCode, seed, l;
    logic [31:0] rng = 32'h000117EC;
    logic [3:0] chans[$];
    int err_total, comparisons, n, lo;

    adc_sequencer_control #(.FIRST_UNIT(1'b1)) dut(.clock(clock), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_pin_n(trigger_pin_n), .timerReq(timerReq), .dmaAck(dmaAck), .cmpIn(cmpIn),
        .analogChan(analogChan), .sampleHold(sampleHold), .dacCode(dacCode),
        .conversionDoneIrq(conversionDoneIrq));
    adc_analog_model fe(.clock(clock), .analogChan(analogChan), .sampleHold(sampleHold), .dacCode(dacCode),
        .seed(seed), .cmpIn(cmpIn));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // record each channel as its sampling window opens
    always @(posedge clock) begin
        if (sampleHold === 1'b1 && shPrev !== 1'b1) chans.push_back(analogChan);
        shPrev <= sampleHold;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic void xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
    endfunction
    // expected result of a channel, from the analog model's input pattern
    function automatic logic [9:0] expRes(input logic [3:0] ch);
        return seed ^ {ch, 6'h15};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitIrq();
        n = 0;
        while (conversionDoneIrq !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, conversionDoneIrq}, 32'h1);
    endtask
    // software reads the flag first so that the zero write counts
    task automatic clrFlag(input logic [7:0] v);
        apb(1'b0, OFF_CSR, 32'h0);
        apb(1'b1, OFF_CSR, {24'h0, v});
        // the interrupt output lags the flag, so a following wait must not see the old level
        repeat (2) @(posedge clock);
    endtask
    // upper byte first, as bus software must
    task automatic chkRes(input logic [3:0] ch);
        l = expRes(ch);
        apb(1'b0, OFF_RES_BASE + {ch, 3'h0}, 32'h0);
        chk(rd, {24'h0, l[9:2]});
        apb(1'b0, OFF_RES_BASE + {ch, 3'h0} + 8'h04, 32'h0);
        chk(rd, {24'h0, l[1:0], 6'h0});
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #800000;
        err_total++;
        report_and_stop();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, timerReq, dmaAck} = 5'h00;
        trigger_pin_n = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        xs();
        seed = rng[9:0];
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        apb(1'b0, OFF_CSR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFF_CR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFF_TRG, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (int i = 0; i < 2; i++) begin
            xs();
            c = rng[3:0];
            lo = (i == 0) ? 518 : 262;
            apb(1'b1, OFF_CSR, {24'h0, 4'h4, c});
            apb(1'b1, OFF_CR, {24'h0, 1'b0, i[0], 1'b1, 5'h0});
            apb(1'b0, OFF_CR, 32'h0);
            chk({31'h0, rd[CR_GO]}, 32'h1);
            waitIrq();
            chk({31'h0, (n + 3 >= lo && n + 3 <= lo + 14)}, 32'h1);
            apb(1'b0, OFF_CR, 32'h0);
            chk({31'h0, rd[CR_GO]}, 32'h0);
            chkRes(c);
            apb(1'b0, OFF_RES_BASE + {c + 4'h1, 3'h0} + 8'h04, 32'h0);
            chk(rd, {24'h0, l[1:0], 6'h0});
            clrFlag(8'h40);
            repeat (3) @(posedge clock);
            chk({31'h0, conversionDoneIrq}, 32'h0);
        end
        xs();
        g = rng[3:2];
        k = rng[1:0];
        chans.delete();
        apb(1'b1, OFF_CSR, {24'h0, 2'h1, MODE_SCAN4, g, k});
        apb(1'b1, OFF_CR, 32'h60);
        waitIrq();
        chk({31'h0, (n >= 262 + 256 * k && n <= 268 + 256 * k)}, 32'h1);
        apb(1'b0, OFF_CR, 32'h0);
        chk({31'h0, rd[CR_GO]}, 32'h0);
        chk(chans.size(), k + 1);
        for (int j = 0; j <= k; j++) begin
            chk(chans[j], 4 * g + j);
            chkRes(4'(4 * g + j));
        end
        clrFlag(8'h70);
        chans.delete();
        apb(1'b1, OFF_CR, 32'h70);
        waitIrq();
        clrFlag(8'h70);
        waitIrq();
        @(posedge clock);
        dmaAck <= 1'b1;
        @(posedge clock);
        dmaAck <= 1'b0;
        repeat (3) @(posedge clock);
        chk({31'h0, conversionDoneIrq}, 32'h0);
        apb(1'b1, OFF_CR, 32'h50);
        apb(1'b0, OFF_CR, 32'h0);
        chk({31'h0, rd[CR_GO]}, 32'h0);
        chk({31'h0, chans.size() >= 6}, 32'h1);
        for (int j = 0; j < 6; j++) chk(chans[j], 4 * (j % 3));
        chans.delete();
        apb(1'b1, OFF_CR, 32'h70);
        repeat (40) @(posedge clock);
        chk(chans.size(), 1);
        chk(chans[0], 32'h0);
        apb(1'b1, OFF_CR, 32'h50);
        clrFlag(8'h40);
        apb(1'b1, OFF_TRG, 32'h80);
        apb(1'b1, OFF_CR, 32'hC0);
        trigger_pin_n <= 1'b0;
        repeat (4) @(posedge clock);
        apb(1'b0, OFF_CR, 32'h0);
        chk({31'h0, rd[CR_GO]}, 32'h1);
        waitIrq();
        repeat (4) @(posedge clock);
        apb(1'b0, OFF_CR, 32'h0);
        chk({31'h0, rd[CR_GO]}, 32'h1);
        trigger_pin_n <= 1'b1;
        chkRes(4'h0);
        clrFlag(8'h40);
        waitIrq();
        clrFlag(8'h40);
        apb(1'b1, OFF_TRG, 32'h0);
        timerReq <= 1'b1;
        @(posedge clock);
        timerReq <= 1'b0;
        apb(1'b0, OFF_CR, 32'h0);
        chk({31'h0, rd[CR_GO]}, 32'h1);
        waitIrq();
        apb(1'b1, OFF_CSR, 32'h0);
        repeat (3) @(posedge clock);
        chk({31'h0, conversionDoneIrq}, 32'h0);
        report_and_stop();
    end
endmodule
